// ==== rtl/asq_map.svh ====
// register offsets, field positions, reset values and timing figures of the adc scan sequencer
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH
// register offsets on the host register port
`define ASQ_OFS_SRC_A 8'h6a
`define ASQ_OFS_SRC_B 8'h6b
`define ASQ_OFS_RUN 8'h6c
`define ASQ_OFS_THERM 8'h6d
`define ASQ_OFS_RES_LO 8'h6e
`define ASQ_OFS_RES_HI 8'h6f
// writable bit masks, reserved bits read as zero
`define ASQ_MASK_SRC_A 8'hff
`define ASQ_MASK_SRC_B 8'h07
`define ASQ_MASK_RUN 8'h3f
`define ASQ_MASK_THERM 8'h03
// reset values
`define ASQ_RST_SRC_A 8'h00
`define ASQ_RST_SRC_B 8'h00
`define ASQ_RST_RUN 8'h20
`define ASQ_RST_THERM 8'h02
// field positions
`define ASQ_B_IN_A 0
`define ASQ_B_IN_B 1
`define ASQ_B_TEMP_HI 7
`define ASQ_B_TEMP_LO 2
`define ASQ_B_DCD3 0
`define ASQ_B_DCD0A 1
`define ASQ_B_READ_SEL 2
`define ASQ_B_MODE 0
`define ASQ_B_TS_HI 3
`define ASQ_B_TS_LO 1
`define ASQ_B_ENABLE 4
`define ASQ_B_CLK_EN 5
`define ASQ_B_CFG 0
`define ASQ_B_POL 1
// source indices of a round
`define ASQ_CH_IN_A 4'h0
`define ASQ_CH_IN_B 4'h1
`define ASQ_NSRC 4'ha
// timing: clock period and one millisecond, both in ns
`define ASQ_CLK_NS 32'h0000_0032
`define ASQ_MS_NS 32'h000f_4240
`define ASQ_CYCLES_PER_MS (`ASQ_MS_NS / `ASQ_CLK_NS)
`define ASQ_MAX_MS_W 7
`endif

// ==== rtl/asq_pkg.sv ====
// types shared by the adc scan sequencer
package asq_pkg;
  typedef enum logic [3:0] {
    asq_idle = 4'b0001,
    asq_pick = 4'b0010,
    asq_conv = 4'b0100,
    asq_wait = 4'b1000
  } asq_state_t;
endpackage : asq_pkg

// ==== rtl/asq_round_timer.sv ====
// inter-round delay timer: millisecond prescaler and power-of-two millisecond count
`timescale 1ns/1ps
`default_nettype none
`include "asq_map.svh"
module asq_round_timer #(
  parameter int CYCLES_PER_MS = `ASQ_CYCLES_PER_MS,
  parameter int MS_W = `ASQ_MAX_MS_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] interval,
  output logic expired
);
  localparam int PW = (CYCLES_PER_MS > 1) ? $clog2(CYCLES_PER_MS) : 1;

  // the prescaler and the 64 ms ceiling must fit their counters
  generate
    if (CYCLES_PER_MS < 2 || MS_W < `ASQ_MAX_MS_W) begin : g_bad_cfg
      $error("asq_round_timer: unsupported prescale or width");
    end
  endgenerate

  logic [PW-1:0] pre_reg;
  logic [MS_W-1:0] ms_reg;
  logic [MS_W-1:0] target_reg;
  logic run_reg;

  // one-cycle millisecond enable; the prescaler restarts with each delay so it is exact
  wire ms_tick = run_reg && (pre_reg == PW'(CYCLES_PER_MS - 1));
  wire reached = ms_tick && ((ms_reg + MS_W'(1)) == target_reg);
  // code 001 is 1 ms, each step doubles; code 000 never reaches this timer
  wire [MS_W-1:0] target_next = MS_W'(1) << (interval - 3'h1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_reg <= '0;
      ms_reg <= '0;
      target_reg <= '0;
      run_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= reached;
      if (start) begin
        run_reg <= 1'b1;
        pre_reg <= '0;
        ms_reg <= '0;
        target_reg <= target_next;
      end else if (run_reg) begin
        pre_reg <= ms_tick ? '0 : pre_reg + PW'(1);
        ms_reg <= ms_tick ? ms_reg + MS_W'(1) : ms_reg;
        run_reg <= !reached;
      end
    end
  end
endmodule : asq_round_timer
`default_nettype wire

// ==== rtl/asq_scan_sequencer.sv ====
// adc scan sequencer: source selection, round sequencing, results and thermal flag
// Function
// - with input a enabled each round converts it and stores its 10-bit result for the shared pair.
// - with input b enabled and not configured as thermal flag each round converts it and its result is readable through the pair.
// - with die temperature enabled each round measures it and writes the temperature monitor.
// - with battery voltage enabled each round measures it and writes the battery monitor.
// - with system supply enabled each round measures it and writes the supply monitor.
// - each of the five converter current enables measures that current into its own monitor.
// - the readout select bit shows input a results when clear and input b results when set.
// - repeat mode clear runs one round, set repeats rounds while the converter stays enabled.
// - setting enable starts measuring and single-round mode clears enable after the round.
// - a round converts selected sources one at a time and then, in repeat mode, waits the interval.
// - the 3-bit interval codes none, 1, 2, 4, 8, 16, 32 and 64 ms.
// - the clock enable bit, set after reset, gates the converter clock.
// - with input b configured as thermal flag the device shuts down as soon as it asserts.
// - the polarity bit, set after reset, makes the thermal flag active low when clear.
// - a result is 10 bits, low eight in the low register, top two in bits 1:0 of the high one.
`timescale 1ns/1ps
`default_nettype none
`include "asq_map.svh"
module asq_scan_sequencer #(
  parameter int CYCLES_PER_MS = `ASQ_CYCLES_PER_MS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic conv_start,
  output logic [3:0] conv_channel,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output logic converter_clock_gate,
  output logic mon_wr,
  output logic [3:0] mon_sel,
  output logic [9:0] mon_data,
  input wire logic thermal_flag_in,
  output logic thermal_shutdown,
  output logic scan_busy
);
  // ==========================================================
  // register file
  logic [7:0] src_a_reg;
  logic [7:0] src_b_reg;
  logic [7:0] run_reg;
  logic [7:0] therm_reg;
  logic [9:0] result_a_reg;
  logic [9:0] result_b_reg;
  logic [7:0] run_next;
  asq_pkg::asq_state_t state_reg;
  asq_pkg::asq_state_t state_next;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  logic timer_expired;

  // write decode
  wire wr_src_a = reg_wr && (reg_addr == `ASQ_OFS_SRC_A);
  wire wr_src_b = reg_wr && (reg_addr == `ASQ_OFS_SRC_B);
  wire wr_run = reg_wr && (reg_addr == `ASQ_OFS_RUN);
  wire wr_therm = reg_wr && (reg_addr == `ASQ_OFS_THERM);

  // control fields
  wire mode_repeat = run_reg[`ASQ_B_MODE];
  wire [2:0] interval = run_reg[`ASQ_B_TS_HI:`ASQ_B_TS_LO];
  wire enable_bit = run_reg[`ASQ_B_ENABLE];
  wire clk_en_bit = run_reg[`ASQ_B_CLK_EN];
  wire therm_cfg = therm_reg[`ASQ_B_CFG];
  wire thermal_flag_polarity = therm_reg[`ASQ_B_POL];
  wire read_sel = src_b_reg[`ASQ_B_READ_SEL];

  // ==========================================================
  // source mask, index 0 input a up to index 9 converter 0 phase a
  wire [9:0] src_mask = {src_b_reg[`ASQ_B_DCD0A],
                         src_b_reg[`ASQ_B_DCD3],
                         src_a_reg[`ASQ_B_TEMP_HI:`ASQ_B_TEMP_LO],
                         src_a_reg[`ASQ_B_IN_B] & ~therm_cfg,
                         src_a_reg[`ASQ_B_IN_A]};

  // ==========================================================
  // round sequencing decode
  wire run_ok = enable_bit && clk_en_bit;
  wire in_pick = (state_reg == asq_pkg::asq_pick);
  wire in_conv = (state_reg == asq_pkg::asq_conv);
  wire at_end = (idx_reg == `ASQ_NSRC);
  wire round_end = in_pick && run_ok && at_end;
  wire pick_hit = in_pick && run_ok && !at_end && src_mask[idx_reg];
  wire timer_start = round_end && mode_repeat && (interval != 3'h0);
  wire conv_store = in_conv && conv_done && clk_en_bit;
  wire store_a = conv_store && (conv_channel == `ASQ_CH_IN_A);
  wire store_b = conv_store && (conv_channel == `ASQ_CH_IN_B);
  wire store_mon = conv_store && !store_a && !store_b;

  // a software write wins over the single-round self clear of enable
  always_comb begin
    run_next = run_reg;
    if (wr_run) begin
      run_next = reg_wdata & `ASQ_MASK_RUN;
    end else if (round_end && !mode_repeat) begin
      run_next[`ASQ_B_ENABLE] = 1'b0;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      src_a_reg <= `ASQ_RST_SRC_A;
      src_b_reg <= `ASQ_RST_SRC_B;
      run_reg <= `ASQ_RST_RUN;
      therm_reg <= `ASQ_RST_THERM;
    end else begin
      if (wr_src_a) src_a_reg <= reg_wdata & `ASQ_MASK_SRC_A;
      if (wr_src_b) src_b_reg <= reg_wdata & `ASQ_MASK_SRC_B;
      if (wr_therm) therm_reg <= reg_wdata & `ASQ_MASK_THERM;
      run_reg <= run_next;
    end
  end

  // ==========================================================
  // scan state machine: one index per cycle, one conversion in flight at most
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    case (state_reg)
      asq_pkg::asq_idle: begin
        idx_next = 4'h0;
        if (run_ok) state_next = asq_pkg::asq_pick;
      end
      asq_pkg::asq_pick: begin
        if (!run_ok) begin
          state_next = asq_pkg::asq_idle;
        end else if (at_end) begin
          idx_next = 4'h0;
          if (!mode_repeat) state_next = asq_pkg::asq_idle;
          else if (interval == 3'h0) state_next = asq_pkg::asq_pick;
          else state_next = asq_pkg::asq_wait;
        end else if (src_mask[idx_reg]) begin
          state_next = asq_pkg::asq_conv;
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      asq_pkg::asq_conv: begin
        // a gated converter clock never finishes, so give up the round
        if (!clk_en_bit) begin
          state_next = asq_pkg::asq_idle;
        end else if (conv_done) begin
          state_next = asq_pkg::asq_pick;
          idx_next = idx_reg + 4'h1;
        end
      end
      asq_pkg::asq_wait: begin
        if (!run_ok) state_next = asq_pkg::asq_idle;
        else if (timer_expired) state_next = asq_pkg::asq_pick;
      end
      default: begin
        state_next = asq_pkg::asq_idle;
        idx_next = 4'h0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= asq_pkg::asq_idle;
      idx_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
    end
  end

  // inter-round delay
  asq_round_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS),
    .MS_W(`ASQ_MAX_MS_W)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .start(timer_start),
    .interval(interval),
    .expired(timer_expired)
  );

  // ==========================================================
  // converter handshake and result storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_channel <= 4'h0;
      mon_wr <= 1'b0;
      mon_sel <= 4'h0;
      mon_data <= 10'h000;
      result_a_reg <= 10'h000;
      result_b_reg <= 10'h000;
    end else begin
      conv_start <= pick_hit;
      if (pick_hit) conv_channel <= idx_reg;
      if (store_a) result_a_reg <= conv_data;
      if (store_b) result_b_reg <= conv_data;
      mon_wr <= store_mon;
      if (store_mon) begin
        mon_sel <= conv_channel;
        mon_data <= conv_data;
      end
    end
  end

  // ==========================================================
  // read path: selected result split over the low and high registers
  wire [9:0] sel_result = read_sel ? result_b_reg : result_a_reg;
  wire [7:0] rd_mux =
    (reg_addr == `ASQ_OFS_SRC_A) ? src_a_reg :
    (reg_addr == `ASQ_OFS_SRC_B) ? src_b_reg :
    (reg_addr == `ASQ_OFS_RUN) ? run_reg :
    (reg_addr == `ASQ_OFS_THERM) ? therm_reg :
    (reg_addr == `ASQ_OFS_RES_LO) ? sel_result[7:0] :
    (reg_addr == `ASQ_OFS_RES_HI) ? {6'h00, sel_result[9:8]} :
    8'h00;

  // thermal flag: active level chosen by polarity, only in flag configuration
  wire therm_active = therm_cfg && (thermal_flag_in == thermal_flag_polarity);

  // registered outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      converter_clock_gate <= 1'b1;
      thermal_shutdown <= 1'b0;
      scan_busy <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata <= rd_mux;
      converter_clock_gate <= clk_en_bit;
      thermal_shutdown <= therm_active;
      scan_busy <= (state_next != asq_pkg::asq_idle);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  gated_no_start_a: assert property (conv_start |-> $past(clk_en_bit))
    else $error("conversion started with converter clock gated");
  only_selected_a: assert property (pick_hit |-> src_mask[idx_reg] && run_ok)
    else $error("unselected source started");
  one_at_time_a: assert property (conv_start |-> in_conv ##1 !conv_start)
    else $error("second conversion started while one in flight");
  skip_flag_a: assert property (conv_start |-> !(therm_cfg && conv_channel == `ASQ_CH_IN_B))
    else $error("flag input converted");
  single_clear_a: assert property (round_end && !mode_repeat && !wr_run |=> !enable_bit)
    else $error("enable not cleared after single round");
  repeat_keep_a: assert property (round_end && mode_repeat && !wr_run |=> enable_bit)
    else $error("enable lost in repeat mode");
  store_a_a: assert property (store_a |=> result_a_reg == $past(conv_data))
    else $error("input a result not stored");
  read_low_a: assert property (reg_rd && reg_addr == `ASQ_OFS_RES_LO
      |=> reg_rdata == $past(read_sel ? result_b_reg[7:0] : result_a_reg[7:0]))
    else $error("low result byte wrong");
  read_high_a: assert property (reg_rd && reg_addr == `ASQ_OFS_RES_HI
      |=> reg_rdata[7:2] == 6'h00)
    else $error("high result byte reserved bits set");
  thermal_trip_a: assert property (therm_cfg && thermal_flag_in == thermal_flag_polarity
      && !wr_therm |=> thermal_shutdown)
    else $error("thermal flag did not shut down");
  clock_gate_a: assert property (##1 converter_clock_gate == $past(clk_en_bit))
    else $error("converter clock gate does not follow its bit");

  // ==========================================================
  // further checks on results, sequencing and the thermal flag

  // input b result lands where the shared pair can show it
  store_b_a: assert property (store_b |=> result_b_reg == $past(conv_data))
    else $error("input b result not stored");

  // monitor sources leave on the monitor port one cycle after their answer
  mon_write_a: assert property (store_mon |=> mon_wr && mon_data == $past(conv_data))
    else $error("monitor result not written");
  mon_index_a: assert property (store_mon |=> mon_sel == $past(conv_channel))
    else $error("monitor result tagged with wrong source");

  // the shared pair sources never reach the monitor port
  mon_channel_a: assert property (mon_wr |-> mon_sel > `ASQ_CH_IN_B)
    else $error("analog input result sent to monitor port");

  // the high register shows the top two bits of the selected result
  read_top_a: assert property (reg_rd && reg_addr == `ASQ_OFS_RES_HI
      |=> reg_rdata[1:0] == $past(sel_result[9:8]))
    else $error("high result bits wrong");

  // a gated converter clock freezes both stored results
  results_hold_a: assert property (!clk_en_bit
      |=> $stable(result_a_reg) && $stable(result_b_reg))
    else $error("result changed with converter clock gated");

  // no start may follow a cycle with the clock gated
  gated_quiet_a: assert property (!clk_en_bit |=> !conv_start)
    else $error("start issued after clock gated");

  // an enabled idle sequencer opens its round at the first source
  round_open_a: assert property (state_reg == asq_pkg::asq_idle && run_ok
      |=> in_pick && idx_reg == 4'h0)
    else $error("round did not open at first source");

  // a single round falls back to idle
  single_idle_a: assert property (round_end && !mode_repeat
      |=> state_reg == asq_pkg::asq_idle)
    else $error("single round did not stop");

  // code 000 restarts the round straight away
  back_to_back_a: assert property (round_end && mode_repeat && interval == 3'h0
      |=> in_pick && idx_reg == 4'h0)
    else $error("back to back round did not restart");

  // any other code parks the sequencer in the wait state
  wait_entry_a: assert property (timer_start |=> state_reg == asq_pkg::asq_wait)
    else $error("interval wait not entered");

  // the wait only ends on expiry or when the run is stopped
  wait_hold_a: assert property (state_reg == asq_pkg::asq_wait && run_ok && !timer_expired
      |=> state_reg == asq_pkg::asq_wait)
    else $error("interval wait left early");

  // only real source indices ever reach the converter
  channel_range_a: assert property (conv_start |-> conv_channel < `ASQ_NSRC)
    else $error("start on a source index out of range");

  // with the flag configuration clear the pin never shuts down
  thermal_off_a: assert property (!therm_cfg |=> !thermal_shutdown)
    else $error("shutdown without flag configuration");

  // cleared polarity makes a low flag the active level
  thermal_low_a: assert property (therm_cfg && !thermal_flag_polarity && !thermal_flag_in
      |=> thermal_shutdown)
    else $error("active low flag did not shut down");
endmodule : asq_scan_sequencer
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking testbench of the adc scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rst, reg_wr, reg_rd, conv_done, thermal_flag_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic conv_start, converter_clock_gate, mon_wr, thermal_shutdown, scan_busy;
  logic [3:0] conv_channel, mon_sel, last_ch;
  logic [9:0] conv_data, mon_data;
  int num_errors = 0, num_checks = 0, cyc = 0, n_starts = 0, t_prev = 0, t_last = 0;
  logic [3:0] mon_q[$];

  // =====================================================
  // design and clock
  // short millisecond so that all eight interval codes fit in the run
  asq_scan_sequencer #(.CYCLES_PER_MS(8)) i_dut (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_data(conv_data),
    .converter_clock_gate(converter_clock_gate), .mon_wr(mon_wr), .mon_sel(mon_sel),
    .mon_data(mon_data), .thermal_flag_in(thermal_flag_in),
    .thermal_shutdown(thermal_shutdown), .scan_busy(scan_busy));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // =====================================================
  // helpers
  // each channel gets its own value; those of inputs a and b have nonzero top two bits so the high register shows
  function automatic logic [9:0] dv(input logic [3:0] ch);
    return 10'h2a5 + {6'h00, ch} * 10'h061;
  endfunction : dv
  task automatic chk(input string name, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    chk("reg_rdata", {2'h0, e}, {2'h0, reg_rdata});
  endtask : rd
  // bounded wait for the sequencer to fall idle; running out counts as a mismatch
  task automatic round_wait;
    int k;
    k = 0;
    tick(3);
    while (scan_busy !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    if (k >= 2000) chk("scan_busy", 10'h000, 10'h001);
  endtask : round_wait
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // =====================================================
  // converter core stand-in and monitor port watcher
  // answers two cycles after each start; data is scrambled once the pulse is over
  initial begin
    conv_done = 1'b0;
    conv_data = 10'h000;
    forever begin
      @(posedge mclk);
      if (conv_start === 1'b1) begin
        last_ch = conv_channel;
        n_starts++;
        t_prev = t_last;
        t_last = cyc;
        @(posedge mclk);
        #1 conv_done = 1'b1;
        conv_data = dv(last_ch);
        @(posedge mclk);
        #1 conv_done = 1'b0;
        conv_data = ~conv_data;
      end
    end
  end
  always @(posedge mclk) begin
    if (mon_wr === 1'b1) begin
      mon_q.push_back(mon_sel);
      chk("mon_data", dv(mon_sel), mon_data);
    end
  end

  // =====================================================
  // scenarios
  task automatic t_regs;
    rd(8'h6a, 8'h00);
    rd(8'h6b, 8'h00);
    rd(8'h6c, 8'h20);
    rd(8'h6d, 8'h02);
    chk("clock_gate", 10'h001, {9'h000, converter_clock_gate});
    wr(8'h6e, 8'hff);
    rd(8'h6e, 8'h00);
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h00);
    wr(8'h6b, 8'hff);
    rd(8'h6b, 8'h07);
    wr(8'h6d, 8'hfc);
    rd(8'h6d, 8'h00);
    wr(8'h6d, 8'h02);
    wr(8'h6c, 8'hc0);
    rd(8'h6c, 8'h00);
    wr(8'h6c, 8'h20);
    wr(8'h6b, 8'h00);
  endtask : t_regs
  task automatic t_inputs;
    wr(8'h6a, 8'h01);
    wr(8'h6c, 8'h30);
    round_wait();
    chk("channel", 10'h000, {6'h00, last_ch});
    rd(8'h6e, 8'(dv(4'h0)));
    rd(8'h6f, 8'(dv(4'h0) >> 8));
    rd(8'h6c, 8'h20);
    wr(8'h6a, 8'h02);
    wr(8'h6b, 8'h04);
    wr(8'h6c, 8'h30);
    round_wait();
    rd(8'h6e, 8'(dv(4'h1)));
    rd(8'h6f, 8'(dv(4'h1) >> 8));
    wr(8'h6b, 8'h00);
    rd(8'h6e, 8'(dv(4'h0)));
  endtask : t_inputs
  // every monitor source in one round, expected in ascending channel order
  task automatic t_monitors;
    mon_q.delete();
    wr(8'h6a, 8'hfc);
    wr(8'h6b, 8'h03);
    wr(8'h6c, 8'h30);
    round_wait();
    chk("mon_count", 10'h008, 10'(mon_q.size()));
    foreach (mon_q[i]) chk("mon_sel", 10'(i + 2), {6'h00, mon_q[i]});
  endtask : t_monitors
  // gap between starts in repeat mode, each code against the back-to-back baseline
  task automatic t_interval;
    int base, gap, w, k, lo;
    logic ok;
    base = 0;
    // one source per round, so the gap between starts is round plus interval
    wr(8'h6b, 8'h00);
    wr(8'h6a, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(8'h6c, 8'h31 | 8'(c << 1));
      k = n_starts + 3;
      w = 0;
      while (n_starts < k && w < 3000) begin
        tick(1);
        w++;
      end
      gap = t_last - t_prev;
      lo = (c == 0) ? 0 : (8 << (c - 1));
      if (c == 0) base = gap;
      ok = (w < 3000) && (gap - base >= lo) && (gap - base <= lo + 2);
      chk("round_gap", 10'h001, {9'h000, ok});
    end
    wr(8'h6c, 8'h20);
    round_wait();
  endtask : t_interval
  task automatic t_clock_off;
    int n0;
    wr(8'h6c, 8'h10);
    n0 = n_starts;
    tick(30);
    chk("clock_gate", 10'h000, {9'h000, converter_clock_gate});
    chk("starts", 10'(n0), 10'(n_starts));
    chk("scan_busy", 10'h000, {9'h000, scan_busy});
    rd(8'h6e, 8'(dv(4'h0)));
    wr(8'h6c, 8'h20);
    tick(2);
    chk("clock_gate", 10'h001, {9'h000, converter_clock_gate});
  endtask : t_clock_off
  // flag level against both polarities, then input b skipped while it is a flag
  task automatic t_thermal;
    int n0;
    logic [7:0] cfg[4] = '{8'h03, 8'h03, 8'h01, 8'h01};
    logic fl[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(8'h6d, cfg[i]);
      thermal_flag_in = fl[i];
      tick(2);
      chk("shutdown", {9'h000, ex[i]}, {9'h000, thermal_shutdown});
    end
    wr(8'h6d, 8'h00);
    thermal_flag_in = 1'b0;
    tick(2);
    chk("shutdown", 10'h000, {9'h000, thermal_shutdown});
    wr(8'h6d, 8'h01);
    thermal_flag_in = 1'b1;
    wr(8'h6a, 8'h02);
    n0 = n_starts;
    wr(8'h6c, 8'h30);
    round_wait();
    chk("starts", 10'(n0), 10'(n_starts));
    rd(8'h6c, 8'h20);
  endtask : t_thermal

  // =====================================================
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    thermal_flag_in = 1'b1;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    t_regs();
    t_inputs();
    t_monitors();
    t_interval();
    t_clock_off();
    t_thermal();
    end_of_test();
  end
  // the whole run needs a few thousand cycles; twenty thousand means a hang
  initial begin
    #(50 * 20000);
    num_errors++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
